// >>> include/fspr_regs.svh
// Status and protection register constants of the serial flash.
// Included by the package and the design; definitions only.
`ifndef FSPR_REGS_SVH
`define FSPR_REGS_SVH

// Opcodes
`define FSPR_OP_RDSR1 8'h05
`define FSPR_OP_RDSR2 8'h35
`define FSPR_OP_RDSR3 8'h15
`define FSPR_OP_WREN 8'h06
`define FSPR_OP_WRDI 8'h04
`define FSPR_OP_WRSR1 8'h01
`define FSPR_OP_WRSR2 8'h31
`define FSPR_OP_WRSR3 8'h11
`define FSPR_OP_PROG 8'h02
`define FSPR_OP_ERASE4K 8'h20
`define FSPR_OP_ERASE32K 8'h52
`define FSPR_OP_ERASE64K 8'hD8
`define FSPR_OP_CHIP1 8'h60
`define FSPR_OP_CHIP2 8'hC7
`define FSPR_OP_SECERASE 8'h44
`define FSPR_OP_SECPROG 8'h42

// First status register fields
`define FSPR_SR1_BUSY 0
`define FSPR_SR1_WEL 1
`define FSPR_SR1_EXT_LO 2
`define FSPR_SR1_EXT_HI 4
`define FSPR_SR1_TOPBOT 5
`define FSPR_SR1_GRAN 6
`define FSPR_SR1_LOCKLO 7
// Second status register fields
`define FSPR_SR2_LOCKUP 0
`define FSPR_SR2_QE 1
`define FSPR_SR2_INV 6
// Third status register fields
`define FSPR_SR3_DRV_LO 5
`define FSPR_SR3_DRV_HI 6

// Bits that a status write may change
`define FSPR_SR1_WMASK 8'hFC
`define FSPR_SR2_WMASK 8'h7B
`define FSPR_SR3_WMASK 8'hFF

// Reset values
`define FSPR_SR1_RESET 8'h00
`define FSPR_SR2_RESET 8'h00
`define FSPR_SR3_RESET 8'h60

// Command lengths in whole bytes after the opcode
`define FSPR_ADDR_BYTES 3'h3
`define FSPR_PROG_MIN_BYTES 3'h4
`define FSPR_WRSR_BYTES 3'h1

// Busy counter width in bits, then internal operation durations in clk cycles
`define FSPR_BUSY_W 24
`define FSPR_WRSR_CYC 100
`define FSPR_PROG_CYC 400
`define FSPR_ERASE_CYC 2000
`define FSPR_CHIP_CYC 4000

`endif

// >>> include/fspr_pkg.sv
// Types of the flash status and protection register block.
// Needs fspr_regs.svh on the include path.
`include "fspr_regs.svh"

package fspr_pkg;

  // Serial command phase, Gray along CMD, DATA, READ
  typedef enum logic [1:0] {
    FSPR_CMD = 2'b00,
    FSPR_DATA = 2'b01,
    FSPR_READ = 2'b11,
    FSPR_SKIP = 2'b10
  } fspr_phase_t;

  // Internal operation in progress
  typedef enum logic [1:0] {
    FSPR_OP_IDLE = 2'b00,
    FSPR_OP_WRSR = 2'b01,
    FSPR_OP_ARRAY = 2'b11
  } fspr_op_t;

  typedef struct packed {
    fspr_phase_t phase;
    logic [2:0] bitCnt;
    logic [2:0] byteCnt;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [7:0] wrData;
    logic [1:0] pendSel;
    logic [7:0] pendData;
    logic [7:0] sr1;
    logic [7:0] sr2;
    logic [7:0] sr3;
    logic write_enable_latch;
    fspr_op_t opKind;
    logic [`FSPR_BUSY_W-1:0] busyCnt;
    logic soData;
    logic soEn;
    logic sckPrev;
    logic csPrev;
  } fspr_state_t;

endpackage

// >>> verilog/fspr_sync2.sv
// Two-flop synchroniser for one pin input.
// Input is asynchronous to clk; output is safe for logic.
`timescale 1ns/10ps
`default_nettype none

module fspr_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pin and synchronised copy
  input wire logic pinIn,
  output logic syncOut
);

  logic meta_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      meta_r <= pinIn;
      syncOut <= meta_r;
    end
  end

endmodule

`default_nettype wire

// >>> verilog/fspr_status_regs.sv
// Status and write-protection registers of a serial flash, SPI side.
// Serial clock, select, data in and protect pin come from outside and are
// sampled by clk; serial clock must stay well below clk / 4.
//
// How it works
// - Opcode 15h shifted in, then third status bits driven one per clock.
// - After bit 0 the read wraps to bit 7 while select and clock go on.
// - Every repeated byte shows the live register value.
// - Select released anywhere ends the read, output goes high impedance.
// - Status writes change only read/write bits, read-only bits stay.
// - Drive select is bits 6:5 of third register, reset 11.
// - Lock bits 0,0: status writable whenever write enable latch is set and no operation is busy.
// - Lock bits 0,1 with protect pin low: every status write refused.
// - Lock bits 0,1 with protect pin high: writable when latch set.
// - Lock bits 1,0: status writes blocked until power cycle.
// - Power cycle in lock-down returns both lock bits to 0,0.
// - Invert, granularity, top/bottom and three extent bits drive outputs.
// - Latch clear: program, erase, security and status writes ignored.
// - Write enable latch is 0 after power-up or reset.
// - Latch cleared on write disable and on write op completion or abort.
// - Incomplete or unknown opcode abort keeps latch set.
// - Abort clears latch only after a full write-type opcode.
// - Busy flag 1 while internal program or erase runs, then 0.
// - Latch is bit 1, busy is bit 0 of first status register.
`timescale 1ns/10ps
`default_nettype none
`include "fspr_regs.svh"

module fspr_status_regs #(
  parameter int WRSR_CYC = `FSPR_WRSR_CYC,
  parameter int PROG_CYC = `FSPR_PROG_CYC,
  parameter int ERASE_CYC = `FSPR_ERASE_CYC,
  parameter int CHIP_CYC = `FSPR_CHIP_CYC
) (
  // Clock and power-up reset
  input wire logic clk,
  input wire logic rstn,
  // Serial pins
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic soOe,
  // Write protect pin
  input wire logic writeProtectN,
  // Protection and configuration state
  output logic statusLockUpper,
  output logic statusLockLower,
  output logic protectInvert,
  output logic protectGranularity,
  output logic protectTopBottom,
  output logic [2:0] protectExtent,
  output logic [1:0] outputDriveSelect,
  output logic quadEnable,
  // Latch and busy state
  output logic writeEnableLatch,
  output logic readyBusyFlag
);

  localparam int BUSY_MAX = (1 << `FSPR_BUSY_W) - 1;

  initial begin
    if (WRSR_CYC < 1 || WRSR_CYC > BUSY_MAX ||
        PROG_CYC < 1 || PROG_CYC > BUSY_MAX ||
        ERASE_CYC < 1 || ERASE_CYC > BUSY_MAX ||
        CHIP_CYC < 1 || CHIP_CYC > BUSY_MAX) begin
      $error("fspr_status_regs: operation cycle count out of range");
    end
  end

  fspr_pkg::fspr_state_t s_r;
  fspr_pkg::fspr_state_t s_nxt;

  logic csNSync;
  logic sckSync;
  logic siSync;
  logic wpSync;

  // Select idles high so it resets inactive
  fspr_sync2 #(.RESET_VAL(1'b1)) uSyncCs (
    .clk(clk),
    .rstn(rstn),
    .pinIn(csN),
    .syncOut(csNSync)
  );

  fspr_sync2 #(.RESET_VAL(1'b0)) uSyncSck (
    .clk(clk),
    .rstn(rstn),
    .pinIn(sck),
    .syncOut(sckSync)
  );

  fspr_sync2 #(.RESET_VAL(1'b0)) uSyncSi (
    .clk(clk),
    .rstn(rstn),
    .pinIn(si),
    .syncOut(siSync)
  );

  fspr_sync2 #(.RESET_VAL(1'b0)) uSyncWp (
    .clk(clk),
    .rstn(rstn),
    .pinIn(writeProtectN),
    .syncOut(wpSync)
  );

  // Decode helpers
  function automatic logic isKnownOp(input logic [7:0] op);
    unique case (op)
      `FSPR_OP_RDSR1, `FSPR_OP_RDSR2, `FSPR_OP_RDSR3,
      `FSPR_OP_WREN, `FSPR_OP_WRDI,
      `FSPR_OP_WRSR1, `FSPR_OP_WRSR2, `FSPR_OP_WRSR3,
      `FSPR_OP_PROG, `FSPR_OP_SECPROG,
      `FSPR_OP_ERASE4K, `FSPR_OP_ERASE32K, `FSPR_OP_ERASE64K,
      `FSPR_OP_SECERASE, `FSPR_OP_CHIP1, `FSPR_OP_CHIP2: isKnownOp = 1'b1;
      default: isKnownOp = 1'b0;
    endcase
  endfunction

  function automatic logic isReadOp(input logic [7:0] op);
    isReadOp = (op == `FSPR_OP_RDSR1) || (op == `FSPR_OP_RDSR2) ||
               (op == `FSPR_OP_RDSR3);
  endfunction

  function automatic logic isWrsrOp(input logic [7:0] op);
    isWrsrOp = (op == `FSPR_OP_WRSR1) || (op == `FSPR_OP_WRSR2) ||
               (op == `FSPR_OP_WRSR3);
  endfunction

  function automatic logic isProgOp(input logic [7:0] op);
    isProgOp = (op == `FSPR_OP_PROG) || (op == `FSPR_OP_SECPROG);
  endfunction

  function automatic logic isEraseOp(input logic [7:0] op);
    isEraseOp = (op == `FSPR_OP_ERASE4K) || (op == `FSPR_OP_ERASE32K) ||
                (op == `FSPR_OP_ERASE64K) || (op == `FSPR_OP_SECERASE);
  endfunction

  function automatic logic isChipOp(input logic [7:0] op);
    isChipOp = (op == `FSPR_OP_CHIP1) || (op == `FSPR_OP_CHIP2);
  endfunction

  // Merge of written data, read-only bits untouched
  function automatic logic [7:0] mergeWr(input logic [7:0] cur,
                                         input logic [7:0] data,
                                         input logic [7:0] mask);
    mergeWr = (cur & ~mask) | (data & mask);
  endfunction

  logic busy;
  logic [7:0] sr1Live;
  logic [7:0] readByte;
  logic [1:0] lockBits;
  logic wrsrAllowed;
  logic sckRise;
  logic sckFall;
  logic csActive;
  logic csEnd;
  logic [7:0] byteIn;
  logic wholeBytes;

  assign busy = (s_r.opKind != fspr_pkg::FSPR_OP_IDLE);

  always_comb begin
    sr1Live = s_r.sr1;
    sr1Live[`FSPR_SR1_WEL] = s_r.write_enable_latch;
    sr1Live[`FSPR_SR1_BUSY] = busy;
  end

  // Chosen by opcode from live state, so repeats show updates
  always_comb begin
    unique case (s_r.opcode)
      `FSPR_OP_RDSR1: readByte = sr1Live;
      `FSPR_OP_RDSR2: readByte = s_r.sr2;
      default: readByte = s_r.sr3;
    endcase
  end

  assign lockBits = {s_r.sr2[`FSPR_SR2_LOCKUP], s_r.sr1[`FSPR_SR1_LOCKLO]};

  always_comb begin
    unique case (lockBits)
      2'b00: wrsrAllowed = 1'b1;
      2'b01: wrsrAllowed = wpSync;
      default: wrsrAllowed = 1'b0;
    endcase
  end

  assign sckRise = sckSync & ~s_r.sckPrev;
  assign sckFall = ~sckSync & s_r.sckPrev;
  assign csActive = ~csNSync;
  assign csEnd = ~csActive & s_r.csPrev;
  assign byteIn = {s_r.shift[6:0], siSync};
  assign wholeBytes = (s_r.bitCnt == 3'h0);

  always_comb begin
    s_nxt = s_r;
    s_nxt.sckPrev = sckSync;
    s_nxt.csPrev = csActive;

    // Internal operation timer
    if (busy) begin
      if (s_r.busyCnt == `FSPR_BUSY_W'(1)) begin
        s_nxt.opKind = fspr_pkg::FSPR_OP_IDLE;
        s_nxt.busyCnt = '0;
        s_nxt.write_enable_latch = 1'b0;
        if (s_r.opKind == fspr_pkg::FSPR_OP_WRSR) begin
          unique case (s_r.pendSel)
            2'h1: s_nxt.sr1 = mergeWr(s_r.sr1, s_r.pendData,
                                      `FSPR_SR1_WMASK);
            2'h2: s_nxt.sr2 = mergeWr(s_r.sr2, s_r.pendData,
                                      `FSPR_SR2_WMASK);
            default: s_nxt.sr3 = mergeWr(s_r.sr3, s_r.pendData,
                                         `FSPR_SR3_WMASK);
          endcase
        end
      end else begin
        s_nxt.busyCnt = s_r.busyCnt - `FSPR_BUSY_W'(1);
      end
    end

    if (!csActive) begin
      s_nxt.phase = fspr_pkg::FSPR_CMD;
      s_nxt.bitCnt = 3'h0;
      s_nxt.byteCnt = 3'h0;
      s_nxt.soEn = 1'b0;
      // An unfinished opcode never reaches DATA, so it leaves the latch
      if (csEnd && s_r.phase == fspr_pkg::FSPR_DATA) begin
        if (s_r.opcode == `FSPR_OP_WREN) begin
          if (wholeBytes && s_r.byteCnt == 3'h0) begin
            s_nxt.write_enable_latch = 1'b1;
          end
        end else if (s_r.opcode == `FSPR_OP_WRDI) begin
          if (wholeBytes && s_r.byteCnt == 3'h0) begin
            s_nxt.write_enable_latch = 1'b0;
          end
        end else if (!s_r.write_enable_latch) begin
          // Write-type command without latch: ignored
        end else if (isWrsrOp(s_r.opcode)) begin
          if (wholeBytes && s_r.byteCnt == `FSPR_WRSR_BYTES &&
              wrsrAllowed) begin
            s_nxt.opKind = fspr_pkg::FSPR_OP_WRSR;
            s_nxt.busyCnt = `FSPR_BUSY_W'(WRSR_CYC);
            s_nxt.pendData = s_r.wrData;
            s_nxt.pendSel = (s_r.opcode == `FSPR_OP_WRSR1) ? 2'h1 :
                            (s_r.opcode == `FSPR_OP_WRSR2) ? 2'h2 : 2'h3;
          end else begin
            s_nxt.write_enable_latch = 1'b0;
          end
        end else if (isProgOp(s_r.opcode)) begin
          if (wholeBytes && s_r.byteCnt >= `FSPR_PROG_MIN_BYTES) begin
            s_nxt.opKind = fspr_pkg::FSPR_OP_ARRAY;
            s_nxt.busyCnt = `FSPR_BUSY_W'(PROG_CYC);
          end else begin
            s_nxt.write_enable_latch = 1'b0;
          end
        end else if (isEraseOp(s_r.opcode)) begin
          if (wholeBytes && s_r.byteCnt == `FSPR_ADDR_BYTES) begin
            s_nxt.opKind = fspr_pkg::FSPR_OP_ARRAY;
            s_nxt.busyCnt = `FSPR_BUSY_W'(ERASE_CYC);
          end else begin
            s_nxt.write_enable_latch = 1'b0;
          end
        end else if (isChipOp(s_r.opcode)) begin
          if (wholeBytes && s_r.byteCnt == 3'h0) begin
            s_nxt.opKind = fspr_pkg::FSPR_OP_ARRAY;
            s_nxt.busyCnt = `FSPR_BUSY_W'(CHIP_CYC);
          end else begin
            s_nxt.write_enable_latch = 1'b0;
          end
        end
      end
    end else begin
      if (sckRise) begin
        s_nxt.shift = byteIn;
        s_nxt.bitCnt = s_r.bitCnt + 3'h1;
        if (s_r.bitCnt == 3'h7) begin
          unique case (s_r.phase)
            fspr_pkg::FSPR_CMD: begin
              s_nxt.opcode = byteIn;
              if (isReadOp(byteIn)) begin
                s_nxt.phase = fspr_pkg::FSPR_READ;
                s_nxt.soEn = 1'b1;
              end else if (isKnownOp(byteIn) && !busy) begin
                s_nxt.phase = fspr_pkg::FSPR_DATA;
              end else begin
                // Unknown opcode, or any write while busy
                s_nxt.phase = fspr_pkg::FSPR_SKIP;
              end
            end
            fspr_pkg::FSPR_DATA: begin
              s_nxt.wrData = byteIn;
              if (s_r.byteCnt != 3'h7) begin
                s_nxt.byteCnt = s_r.byteCnt + 3'h1;
              end
            end
            fspr_pkg::FSPR_READ,
            fspr_pkg::FSPR_SKIP: begin
            end
          endcase
        end
      end
      // Bit index wraps 7..0 with the rise count
      if (sckFall && s_r.phase == fspr_pkg::FSPR_READ) begin
        s_nxt.soData = readByte[~s_r.bitCnt];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r.phase <= fspr_pkg::FSPR_CMD;
      s_r.bitCnt <= 3'h0;
      s_r.byteCnt <= 3'h0;
      s_r.shift <= 8'h00;
      s_r.opcode <= 8'h00;
      s_r.wrData <= 8'h00;
      s_r.pendSel <= 2'h0;
      s_r.pendData <= 8'h00;
      s_r.sr1 <= `FSPR_SR1_RESET;
      s_r.sr2 <= `FSPR_SR2_RESET;
      s_r.sr3 <= `FSPR_SR3_RESET;
      s_r.write_enable_latch <= 1'b0;
      s_r.opKind <= fspr_pkg::FSPR_OP_IDLE;
      s_r.busyCnt <= '0;
      s_r.soData <= 1'b0;
      s_r.soEn <= 1'b0;
      s_r.sckPrev <= 1'b0;
      s_r.csPrev <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Pin and field outputs from flops; busy flag decoded from opKind
  assign so = s_r.soData;
  assign soOe = s_r.soEn;
  assign statusLockUpper = s_r.sr2[`FSPR_SR2_LOCKUP];
  assign statusLockLower = s_r.sr1[`FSPR_SR1_LOCKLO];
  assign protectInvert = s_r.sr2[`FSPR_SR2_INV];
  assign protectGranularity = s_r.sr1[`FSPR_SR1_GRAN];
  assign protectTopBottom = s_r.sr1[`FSPR_SR1_TOPBOT];
  assign protectExtent = s_r.sr1[`FSPR_SR1_EXT_HI:`FSPR_SR1_EXT_LO];
  assign outputDriveSelect = s_r.sr3[`FSPR_SR3_DRV_HI:`FSPR_SR3_DRV_LO];
  assign quadEnable = s_r.sr2[`FSPR_SR2_QE];
  assign writeEnableLatch = s_r.write_enable_latch;
  assign readyBusyFlag = busy;

endmodule

`default_nettype wire

// >>> bench/fspr_status_regs_asserts.sv
// Concurrent checks on the pins of the status register block.
// Bound to fspr_status_regs; sees its ports only.
`timescale 1ns/10ps
`default_nettype none

module fspr_status_regs_asserts #(
  parameter int WRSR_CYC = 100,
  parameter int PROG_CYC = 400,
  parameter int ERASE_CYC = 2000,
  parameter int CHIP_CYC = 4000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Serial pins
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic soOe,
  input wire logic writeProtectN,
  // Register state
  input wire logic statusLockUpper,
  input wire logic statusLockLower,
  input wire logic protectInvert,
  input wire logic protectGranularity,
  input wire logic protectTopBottom,
  input wire logic [2:0] protectExtent,
  input wire logic [1:0] outputDriveSelect,
  input wire logic quadEnable,
  input wire logic writeEnableLatch,
  input wire logic readyBusyFlag
);
  logic [15:0] busyLen_r;
  logic [10:0] fields;

  assign fields = {statusLockUpper, statusLockLower, protectInvert,
    protectGranularity, protectTopBottom, protectExtent,
    outputDriveSelect, quadEnable};

  // Busy-high cycles so far; read at the falling edge of the flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busyLen_r <= 16'h0000;
    end else if (readyBusyFlag) begin
      busyLen_r <= busyLen_r + 16'h0001;
    end else begin
      busyLen_r <= 16'h0000;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_reset_values:
    assert property ($rose(rstn) |-> outputDriveSelect == 2'h3 &&
      !writeEnableLatch && !readyBusyFlag && !statusLockUpper &&
      !statusLockLower) else $error("values after reset wrong");
  a_oe_release:
    assert property ($rose(csN) |-> ##[1:5] !soOe)
    else $error("output not released after select");
  a_latch_busy:
    assert property (readyBusyFlag |-> writeEnableLatch)
    else $error("busy without write enable latch");
  a_busy_start:
    assert property ($rose(readyBusyFlag) |-> $past(writeEnableLatch))
    else $error("operation started with latch clear");
  a_busy_end:
    assert property ($fell(readyBusyFlag) |-> !writeEnableLatch)
    else $error("latch still set after operation");
  a_busy_len:
    assert property ($fell(readyBusyFlag) |-> busyLen_r == WRSR_CYC ||
      busyLen_r == PROG_CYC || busyLen_r == ERASE_CYC ||
      busyLen_r == CHIP_CYC) else $error("busy length wrong");
  a_lock_hold:
    assert property (statusLockUpper |=> $stable(fields))
    else $error("status changed during lock-down");
  a_wp_lock:
    assert property ((!writeProtectN && statusLockLower &&
      !statusLockUpper) [*8] |=> $stable(outputDriveSelect))
    else $error("status written while pin protected");
  a_field_change:
    assert property ($changed(fields) |-> $past(readyBusyFlag) &&
      !readyBusyFlag) else $error("field changed outside write end");
  a_so_edge:
    assert property (soOe && $past(soOe) && $changed(so) |-> !sck)
    else $error("output changed with serial clock high");

  cover property ($fell(readyBusyFlag));
  cover property ($rose(soOe));
  cover property (statusLockUpper && statusLockLower);
endmodule

bind fspr_status_regs fspr_status_regs_asserts #(
  .WRSR_CYC(WRSR_CYC), .PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC),
  .CHIP_CYC(CHIP_CYC)
) i_asserts (
  .clk(clk), .rstn(rstn), .csN(csN), .sck(sck), .si(si), .so(so),
  .soOe(soOe), .writeProtectN(writeProtectN),
  .statusLockUpper(statusLockUpper), .statusLockLower(statusLockLower),
  .protectInvert(protectInvert), .protectGranularity(protectGranularity),
  .protectTopBottom(protectTopBottom), .protectExtent(protectExtent),
  .outputDriveSelect(outputDriveSelect), .quadEnable(quadEnable),
  .writeEnableLatch(writeEnableLatch), .readyBusyFlag(readyBusyFlag)
);
`default_nettype wire

// >>> bench/fspr_spi_host.sv
// Model of the SPI host in front of the status register block.
// Runs off the falling edge of clk; serial clock period is 8 clk.
`timescale 1ns/10ps
`default_nettype none

module fspr_spi_host (
  // Bench clock
  input wire logic clk,
  // Serial pins
  output logic csN,
  output logic sck,
  output logic si,
  input wire logic so,
  input wire logic soOe
);
  initial begin
    csN = 1'h1;
    sck = 1'h0;
    si = 1'h0;
  end

  // Frame of nOp opcode bits, nDat data bits and nRd bits read back
  task automatic frame(input logic [7:0] op, input int nOp,
      input logic [7:0] d, input int nDat, input int nRd,
      output logic [63:0] rd);
    int n;
    rd = 64'h0;
    n = nOp + ((nDat > nRd) ? nDat : nRd);
    csN = 1'h0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      // Opcode then data, MSB first, set while sck is low
      if (i < nOp) si = op[7 - i];
      else if (i - nOp < nDat) si = d[7 - ((i - nOp) % 8)];
      else si = ~si;
      repeat (4) @(negedge clk);
      sck = 1'h1;
      // A released output reads as unknown, so it cannot pass
      if (i >= nOp) rd = {rd[62:0], soOe ? so : 1'hx};
      repeat (4) @(negedge clk);
      sck = 1'h0;
    end
    repeat (4) @(negedge clk);
    // Release may come mid-byte
    csN = 1'h1;
    si = ~si;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// >>> bench/fspr_status_regs_tb.sv
// Self-checking bench of the status register block.
// Host model drives the serial pins; tasks below build commands.
`timescale 1ns/10ps
`default_nettype none
`include "fspr_regs.svh"

`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", nm, e, a); end end

module fspr_status_regs_tb;
  logic clk = 1'h0;
  logic rstn;
  logic writeProtectN;
  logic csN, sck, si, so, soOe;
  logic lockUp, lockLo, inv, gran, topBot, qe, write_enable_latch, busy;
  logic [2:0] ext;
  logic [1:0] drv;
  logic [63:0] rd;
  int fails = 0;
  int checked = 0;

  always #25 clk = ~clk;

  fspr_spi_host i_host (.clk(clk), .csN(csN), .sck(sck), .si(si),
    .so(so), .soOe(soOe));

  fspr_status_regs #(.WRSR_CYC(165), .PROG_CYC(12), .ERASE_CYC(14),
    .CHIP_CYC(20)) i_dut (
    .clk(clk), .rstn(rstn), .csN(csN), .sck(sck), .si(si), .so(so),
    .soOe(soOe), .writeProtectN(writeProtectN), .statusLockUpper(lockUp),
    .statusLockLower(lockLo), .protectInvert(inv),
    .protectGranularity(gran), .protectTopBottom(topBot),
    .protectExtent(ext), .outputDriveSelect(drv), .quadEnable(qe),
    .writeEnableLatch(write_enable_latch), .readyBusyFlag(busy));

  task automatic test_done;
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] d,
      input int nDat);
    i_host.frame(op, 8, d, nDat, 0, rd);
  endtask

  task automatic rdReg(input logic [7:0] op, input int n);
    i_host.frame(op, 8, 8'h00, 0, n, rd);
  endtask

  task automatic waitIdle;
    for (int k = 0; k < 400 && busy !== 1'h0; k++) @(negedge clk);
  endtask

  task automatic wrStatus(input logic [7:0] op, input logic [7:0] d);
    cmd(`FSPR_OP_WREN, 8'h00, 0);
    cmd(op, d, 8);
    waitIdle();
  endtask

  task automatic doReset;
    rstn = 1'h0;
    repeat (8) @(negedge clk);
    rstn = 1'h1;
    repeat (4) @(negedge clk);
  endtask

  initial begin
    rstn = 1'h0;
    writeProtectN = 1'h0;
    doReset();
    `CHK("drive reset", 2'h3, drv)
    `CHK("latch reset", 1'h0, write_enable_latch)
    rdReg(`FSPR_OP_RDSR3, 16);
    `CHK("sr3 repeat", 16'h6060, rd[15:0])
    `CHK("so released", 1'h0, soOe)
    cmd(`FSPR_OP_WRSR3, 8'h9A, 8);
    waitIdle();
    `CHK("write without latch", 2'h3, drv)
    cmd(`FSPR_OP_WREN, 8'h00, 0);
    rdReg(`FSPR_OP_RDSR1, 8);
    `CHK("latch bit", 8'h02, rd[7:0])
    cmd(`FSPR_OP_WRSR3, 8'h9A, 8);
    // Polled while busy: first byte busy, second byte done
    rdReg(`FSPR_OP_RDSR1, 16);
    `CHK("busy polled", 16'h0300, rd[15:0])
    waitIdle();
    rdReg(`FSPR_OP_RDSR3, 8);
    `CHK("sr3 written", 8'h9A, rd[7:0])
    `CHK("drive full", 2'h0, drv)
    writeProtectN = 1'h1;
    wrStatus(`FSPR_OP_WRSR1, 8'hFF);
    rdReg(`FSPR_OP_RDSR1, 8);
    `CHK("sr1 read-only bits", 8'hFC, rd[7:0])
    `CHK("protect fields", 6'h3F, {lockLo, gran, topBot, ext})
    writeProtectN = 1'h0;
    wrStatus(`FSPR_OP_WRSR3, 8'h60);
    `CHK("pin locked", 3'h0, {drv, write_enable_latch})
    writeProtectN = 1'h1;
    wrStatus(`FSPR_OP_WRSR3, 8'h20);
    `CHK("pin unlocked", 2'h1, drv)
    wrStatus(`FSPR_OP_WRSR2, 8'h01);
    wrStatus(`FSPR_OP_WRSR3, 8'h40);
    `CHK("both locks", 4'hD, {lockUp, lockLo, drv})
    doReset();
    wrStatus(`FSPR_OP_WRSR2, 8'h01);
    wrStatus(`FSPR_OP_WRSR3, 8'h00);
    `CHK("lock-down", 4'hB, {lockUp, lockLo, drv})
    doReset();
    `CHK("lock cleared", 2'h0, {lockUp, lockLo})
    wrStatus(`FSPR_OP_WRSR2, 8'hC2);
    rdReg(`FSPR_OP_RDSR2, 8);
    `CHK("sr2 read-only bit", 8'h42, rd[7:0])
    `CHK("invert", 1'h1, inv)
    `CHK("quad enable", 1'h1, qe)
    cmd(`FSPR_OP_WREN, 8'h00, 0);
    i_host.frame(`FSPR_OP_PROG, 4, 8'h00, 0, 0, rd);
    `CHK("partial opcode", 1'h1, write_enable_latch)
    cmd(8'hAB, 8'h00, 0);
    `CHK("unknown opcode", 1'h1, write_enable_latch)
    cmd(`FSPR_OP_PROG, 8'h00, 0);
    `CHK("aborted program", 1'h0, write_enable_latch)
    cmd(`FSPR_OP_WREN, 8'h00, 0);
    cmd(`FSPR_OP_WRDI, 8'h00, 0);
    `CHK("write disable", 1'h0, write_enable_latch)
    cmd(`FSPR_OP_WREN, 8'h00, 0);
    cmd(`FSPR_OP_ERASE4K, 8'h00, 16);
    `CHK("short erase", 2'h0, {busy, write_enable_latch})
    cmd(`FSPR_OP_WREN, 8'h00, 0);
    cmd(`FSPR_OP_ERASE4K, 8'h00, 24);
    `CHK("block erase busy", 2'h3, {busy, write_enable_latch})
    waitIdle();
    `CHK("block erase done", 2'h0, {busy, write_enable_latch})
    cmd(`FSPR_OP_WREN, 8'h00, 0);
    cmd(`FSPR_OP_PROG, 8'hA5, 32);
    `CHK("program busy", 2'h3, {busy, write_enable_latch})
    waitIdle();
    `CHK("program done", 2'h0, {busy, write_enable_latch})
    cmd(`FSPR_OP_WREN, 8'h00, 0);
    cmd(`FSPR_OP_CHIP1, 8'h00, 0);
    `CHK("erase busy", 2'h3, {busy, write_enable_latch})
    waitIdle();
    `CHK("erase done", 2'h0, {busy, write_enable_latch})
    rdReg(`FSPR_OP_RDSR3, 3);
    `CHK("mid-byte read", 3'h3, rd[2:0])
    `CHK("so released", 1'h0, soOe)
    test_done();
  end

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
